/* rtl/halt_ctl_pkg.sv */
/*
  Package for the debug halt, step and ram controller: AXI4-Lite register
  offsets, field positions, reset values, halt cause codes, command codes
  and timing constants. Assumes a 250 MHz core clock.
*/
package halt_ctl_pkg;

  localparam logic [3:0] OFF_CMD = 4'h0;
  localparam logic [3:0] OFF_STATUS = 4'h4;
  localparam logic [3:0] OFF_RAM = 4'h8;
  localparam logic [3:0] OFF_CFG = 4'hC;

  localparam logic [2:0] CMD_CLEAR = 3'h0;
  localparam logic [2:0] CMD_HALT = 3'h1;
  localparam logic [2:0] CMD_RESTART = 3'h2;
  localparam logic [2:0] CMD_STEP = 3'h3;
  localparam logic [2:0] CMD_SOFT_RST = 3'h5;
  localparam logic [2:0] CMD_HARD_RST = 3'h6;
  localparam logic [2:0] CMD_FORCE = 3'h7;

  localparam logic [2:0] HC_NONE = 3'h0;
  localparam logic [2:0] HC_FORCE = 3'h1;
  localparam logic [2:0] HC_WDOG = 3'h2;
  localparam logic [2:0] HC_MCHK = 3'h3;
  localparam logic [2:0] HC_DEBUG = 3'h4;
  localparam logic [2:0] HC_PROG = 3'h5;
  localparam logic [2:0] HC_HREQ = 3'h6;
  localparam logic [2:0] HC_HWFAIL = 3'h7;

  // Status word fields
  localparam int ST_HC_LSB = 0;
  localparam int ST_HALTED = 3;
  localparam int ST_PEND = 4;
  localparam int ST_TRAP = 5;
  localparam int ST_ERR = 6;
  localparam int ST_STEP = 7;
  localparam int ST_RAM = 8;
  localparam int ST_DONE = 9;

  // Configuration word fields
  localparam int CFG_WDOG_HALT = 0;
  localparam int CFG_TRAP_HALT = 1;
  localparam int CFG_ADDR_MATCH = 2;

  localparam logic [31:0] CFG_RESET = 32'h0000_0000;

  // Ram completion bound and spacing, in cycles, and the clock period in ns
  localparam int RAM_DONE_CYC = 3;
  localparam int RAM_SPACING_CYC = 4;
  localparam int CLK_PERIOD_NS = 4;

  // Program-written debug reset field value that requests a halt
  localparam logic [1:0] PROG_HALT_VAL = 2'h3;

  typedef enum logic [1:0] {
    RESP_OKAY = 2'h0,
    RESP_SLVERR = 2'h2
  } resp_t;

endpackage : halt_ctl_pkg

/* rtl/halt_ctl.sv */
/*
  Debug halt controller: records the halt cause, drives the error output,
  and runs single step and ram sequences for an embedded 32-bit core.
  Assumes the core pipeline reports completion, exceptions and debug
  events through the core_* inputs, one cycle pulses, synchronous to aclk.
*/
// The register offsets and the AXI4-Lite interface to the registers were decided locally.
// Summary of operation
// RL1: codes 000, 001, 110 without error
// RL2: second watchdog event halts code 010, error
// RL3: machine check with enable off: 011, error
// RL4: program reset field halt: code 101, error
// RL5: trap or address match: code 100
// RL6: invalid control state: code 111, error
// RL7: exit halt on reset, restart, step, ram
// RL8: hard reset request clears halt pending
// RL9: other resets keep halt pending
// RL10: step or ram returns to halted
// RL11: synchronous exception: take it, halt at vector
// RL12: step runs one instruction; debug event halts first
// RL13: pending async interrupt on step: take, halt
// RL14: step-caused async interrupt waits next step
// RL15: ramming suppresses fetch address updates
// RL16: ram msr moves and rfi skip sync
// RL17: rammed sync still synchronises normally
// RL18: ram timer status move writes directly
// RL19: rammed trap: interrupt or trap status
// RL20: async interrupts ignored while ramming
// RL21: sync priority kept; no fetch exceptions
// RL22: address match events suppressed while ramming
// RL23: halted flag only when halted and idle
// RL24: force halt shows halted within two cycles
// RL25: ram writes ignored unless halted
// RL26: simple rammed ops finish in 3 cycles
`timescale 1ns/1ps
module halt_ctl
  import halt_ctl_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic hreset_req,
  input wire logic halt_req,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic core_done,
  input wire logic core_sync_exc,
  input wire logic core_async_pend,
  input wire logic core_dbg_event,
  input wire logic core_trap,
  input wire logic core_wdog_second,
  input wire logic core_mchk,
  input wire logic core_mchk_enable,
  input wire logic core_unmask_enable,
  input wire logic core_unmaskable_int,
  input wire logic core_prog_halt,
  input wire logic [1:0] core_prog_rst_field,
  output logic error_out,
  output logic halted_flag,
  output logic core_run,
  output logic core_soft_rst,
  output logic ram_valid,
  output logic [31:0] ram_instruction_reg,
  output logic ram_mode,
  output logic step_mode,
  output logic async_int_allow,
  output logic addr_match_enable,
  output logic fetch_addr_update,
  output logic msr_sync_skip,
  output logic timer_direct_write,
  output logic trap_halt_enable
);

  typedef enum logic [2:0] {S_RUN, S_HALTING, S_HALTED, S_STEP, S_RAM} state_t;

  state_t state_r;
  logic [2:0] hc_r;
  logic halt_pending_flag_r;
  logic trap_flag_r;
  logic err_r;
  logic [31:0] cfg_r;
  logic [1:0] ram_age_r;
  logic aw_held_r;
  logic w_held_r;
  logic [3:0] awaddr_r;
  logic [31:0] wdata_r;
  logic wr_go;
  logic ram_ok;
  logic cmd_wr;
  logic [2:0] cmd;
  logic halt_cause;
  logic [2:0] cause_code;
  logic cause_err;
  logic bad_state;
  logic step_pend_r;

  // Write channel capture; address and data may arrive in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= 4'h0;
      wdata_r <= 32'h0000_0000;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_held_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        wdata_r <= s_axi_wdata;
      end else if (wr_go) begin
        w_held_r <= 1'b0;
      end
    end
  end

  assign wr_go = aw_held_r && w_held_r && !s_axi_bvalid;
  assign cmd_wr = wr_go && awaddr_r == OFF_CMD;
  assign cmd = wdata_r[2:0];
  // A ram write outside the halted state is refused with SLVERR
  assign ram_ok = state_r == S_HALTED && ram_age_r == 2'h0; // see RL25

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_held_r && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_held_r && !(s_axi_wvalid && s_axi_wready);
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        if (awaddr_r == OFF_RAM && !ram_ok) begin
          s_axi_bresp <= RESP_SLVERR; // see RL25
        end else if (awaddr_r == OFF_STATUS) begin
          s_axi_bresp <= RESP_SLVERR;
        end else begin
          s_axi_bresp <= RESP_OKAY;
        end
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_r <= CFG_RESET;
    end else if (wr_go && awaddr_r == OFF_CFG && s_axi_wstrb[0]) begin
      cfg_r <= {29'h0, wdata_r[2:0]};
    end
  end

  // Read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= RESP_OKAY;
        unique case (s_axi_araddr)
          OFF_STATUS: s_axi_rdata <= {22'h0, state_r == S_HALTED && ram_age_r == 2'h0,
                                      state_r == S_RAM, state_r == S_STEP, err_r,
                                      trap_flag_r, halt_pending_flag_r,
                                      state_r == S_HALTED, hc_r};
          OFF_RAM: s_axi_rdata <= ram_instruction_reg;
          OFF_CFG: s_axi_rdata <= cfg_r;
          OFF_CMD: s_axi_rdata <= 32'h0000_0000;
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Halt cause priority: hardware failure first, then errors, then the rest
  assign bad_state = !(state_r inside {S_RUN, S_HALTING, S_HALTED, S_STEP, S_RAM});
  always_comb begin
    halt_cause = 1'b1;
    cause_err = 1'b0;
    cause_code = HC_NONE;
    if (bad_state) begin
      cause_code = HC_HWFAIL; // see RL6
      cause_err = 1'b1;
    end else if (core_mchk && !core_mchk_enable) begin
      cause_code = HC_MCHK; // see RL3
      cause_err = 1'b1;
    end else if (core_unmaskable_int && !core_unmask_enable && !core_mchk_enable) begin
      cause_code = HC_MCHK; // see RL3
      cause_err = 1'b1;
    end else if (core_wdog_second && cfg_r[CFG_WDOG_HALT]) begin
      cause_code = HC_WDOG; // see RL2
      cause_err = 1'b1;
    end else if (core_prog_halt && core_prog_rst_field == PROG_HALT_VAL) begin
      cause_code = HC_PROG; // see RL4
      cause_err = 1'b1;
    end else if (core_dbg_event && state_r != S_RAM && cfg_r[CFG_ADDR_MATCH]) begin
      cause_code = HC_DEBUG; // see RL5 RL12 RL22
    end else if (core_trap && cfg_r[CFG_TRAP_HALT]) begin
      cause_code = HC_DEBUG; // see RL5 RL19
    end else if (halt_req) begin
      cause_code = HC_HREQ; // see RL1
    end else if (cmd_wr && cmd inside {CMD_HALT, CMD_FORCE}) begin
      cause_code = HC_FORCE; // see RL1
    end else begin
      halt_cause = 1'b0;
    end
  end

  // Core control state machine
  always_ff @(posedge aclk) begin
    if (!aresetn || hreset_req) begin
      state_r <= S_RUN;
    end else if (bad_state) begin
      state_r <= S_HALTED; // see RL6
    end else if (cmd_wr && cmd == CMD_FORCE) begin
      state_r <= S_HALTED; // see RL24
    end else begin
      unique case (state_r)
        S_RUN: begin
          if (halt_cause || halt_pending_flag_r) begin
            state_r <= S_HALTING;
          end
        end
        S_HALTING: begin
          if (core_done) begin
            state_r <= S_HALTED; // see RL23
          end
        end
        S_HALTED: begin
          if (cmd_wr && cmd == CMD_RESTART) begin
            state_r <= S_RUN; // see RL7
          end else if (cmd_wr && cmd == CMD_STEP) begin
            state_r <= S_STEP; // see RL7 RL13
          end else if (wr_go && awaddr_r == OFF_RAM && ram_ok) begin
            state_r <= S_RAM; // see RL7
          end
        end
        S_STEP, S_RAM: begin
          if (core_done || core_sync_exc || halt_cause) begin
            state_r <= S_HALTED; // see RL10 RL11
          end
        end
        default: begin
          state_r <= S_HALTED; // see RL6
        end
      endcase
    end
  end

  // Halt pending survives soft resets and program resets
  always_ff @(posedge aclk) begin
    if (!aresetn || hreset_req) begin
      halt_pending_flag_r <= 1'b0; // see RL8
    end else if (halt_cause) begin
      halt_pending_flag_r <= 1'b1;
    end else if (cmd_wr && cmd == CMD_RESTART &&
                 (state_r == S_HALTED || !halt_pending_flag_r)) begin
      halt_pending_flag_r <= 1'b0; // see RL9
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || hreset_req) begin
      hc_r <= HC_NONE;
      err_r <= 1'b0;
      trap_flag_r <= 1'b0;
    end else if (halt_cause) begin
      hc_r <= cause_code;
      err_r <= err_r | cause_err;
      trap_flag_r <= trap_flag_r | (core_trap && cfg_r[CFG_TRAP_HALT]); // see RL19
    end else if (cmd_wr && cmd == CMD_CLEAR && state_r == S_HALTED) begin
      hc_r <= HC_NONE;
      err_r <= 1'b0;
      trap_flag_r <= 1'b0;
    end
  end

  // Ram age counts the completion bound so paced writes are never lost
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ram_age_r <= 2'h0;
      ram_instruction_reg <= 32'h0000_0000;
      ram_valid <= 1'b0;
    end else begin
      ram_valid <= wr_go && awaddr_r == OFF_RAM && ram_ok;
      if (wr_go && awaddr_r == OFF_RAM && ram_ok) begin
        ram_instruction_reg <= wdata_r;
        ram_age_r <= 2'(RAM_DONE_CYC - 1); // see RL26
      end else if (ram_age_r != 2'h0) begin
        ram_age_r <= ram_age_r - 2'h1;
      end
    end
  end

  // Sampled every halted cycle, so it holds the pending state at step entry;
  // an interrupt raised by the stepped instruction itself waits for the next step
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      step_pend_r <= 1'b0;
    end else if (state_r == S_HALTED) begin
      step_pend_r <= core_async_pend; // see RL13 RL14
    end
  end

  // Core-facing mode lines
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      error_out <= 1'b0;
      halted_flag <= 1'b0;
      core_run <= 1'b0;
      core_soft_rst <= 1'b0;
      ram_mode <= 1'b0;
      step_mode <= 1'b0;
      async_int_allow <= 1'b0;
      addr_match_enable <= 1'b0;
      fetch_addr_update <= 1'b0;
      msr_sync_skip <= 1'b0;
      timer_direct_write <= 1'b0;
      trap_halt_enable <= 1'b0;
    end else begin
      error_out <= err_r;
      halted_flag <= state_r == S_HALTED; // see RL23 RL24
      core_run <= state_r == S_RUN || state_r == S_STEP || state_r == S_RAM;
      core_soft_rst <= cmd_wr && cmd inside {CMD_SOFT_RST, CMD_HARD_RST}; // see RL9
      ram_mode <= state_r == S_RAM;
      step_mode <= state_r == S_STEP; // see RL12
      // Step takes an interrupt already pending at entry only; new ones wait
      async_int_allow <= state_r != S_RAM &&
                         (state_r != S_STEP || step_pend_r); // see RL13 RL14 RL20
      addr_match_enable <= state_r != S_RAM && cfg_r[CFG_ADDR_MATCH]; // see RL22
      fetch_addr_update <= state_r != S_RAM; // see RL15 RL21
      msr_sync_skip <= state_r == S_RAM; // see RL16 RL17
      timer_direct_write <= state_r == S_RAM; // see RL18
      trap_halt_enable <= cfg_r[CFG_TRAP_HALT]; // see RL19
    end
  end

endmodule : halt_ctl

/* tb/halt_ctl_properties.sv */
/*
  Checker for halt_ctl: ram mode gating, halt timing, error and reset.
  Assumes one clock domain and sees only the ports of halt_ctl.
*/
`timescale 1ns/1ps
module halt_ctl_properties
  import halt_ctl_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic hreset_req,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic core_mchk,
  input wire logic core_mchk_enable,
  input wire logic core_async_pend,
  input wire logic error_out,
  input wire logic halted_flag,
  input wire logic core_run,
  input wire logic ram_mode,
  input wire logic step_mode,
  input wire logic async_int_allow,
  input wire logic addr_match_enable,
  input wire logic fetch_addr_update,
  input wire logic msr_sync_skip,
  input wire logic timer_direct_write
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_force_wr;
    s_axi_awvalid && s_axi_awready && s_axi_awaddr == OFF_CMD && s_axi_wvalid && s_axi_wready
      && s_axi_wdata[2:0] == CMD_FORCE;
  endsequence
  sequence s_ram_start;
    $rose(ram_mode);
  endsequence
  sequence s_step_start;
    $rose(step_mode);
  endsequence
  a_reset_quiet: assert property ($rose(aresetn) |-> !halted_flag && !error_out ##1 core_run)
    else $error("outputs wrong after reset");
  a_ram_no_fetch: assert property (ram_mode |-> !fetch_addr_update)
    else $error("fetch update while ramming");
  a_ram_no_async: assert property (ram_mode |-> !async_int_allow)
    else $error("async interrupt allowed while ramming");
  a_ram_no_match: assert property (ram_mode |-> !addr_match_enable)
    else $error("address match enabled while ramming");
  a_ram_sync_skip: assert property (ram_mode |-> msr_sync_skip && timer_direct_write)
    else $error("ram mode side controls missing");
  a_halted_idle: assert property (halted_flag |-> !core_run && !ram_mode && !step_mode)
    else $error("halted while still busy");
  a_force_fast: assert property (s_force_wr |-> ##[1:4] halted_flag)
    else $error("force halt too slow");
  a_ram_returns: assert property (s_ram_start |-> ##[1:12] halted_flag)
    else $error("no return to halted after ram");
  a_hreset_clear: assert property (hreset_req |=> ##1 !error_out && !halted_flag)
    else $error("hard reset did not clear halt");
  a_step_returns: assert property (s_step_start |-> ##[1:12] halted_flag)
    else $error("no return to halted after step");
  a_step_irq_entry: assert property (
    s_step_start |-> async_int_allow == $past(core_async_pend, 2))
    else $error("step interrupt gate wrong at entry");
  a_mchk_error: assert property (core_mchk && !core_mchk_enable |-> ##[1:8] error_out)
    else $error("machine check without error output");
endmodule : halt_ctl_properties

bind halt_ctl halt_ctl_properties i_props (.*);

/* tb/core_stub.sv */
/*
  Core pipeline stand-in: reports completion while the controller is
  not halted. Assumes halted_flag from halt_ctl on the same clock.
*/
`timescale 1ns/1ps
module core_stub
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic halted_flag,
  output logic core_done
);
  logic [1:0] cnt_r;
  logic slow_r;
  // Alternates prompt and slow completion, never beyond three cycles
  always_ff @(posedge aclk) begin
    if (!aresetn || halted_flag) begin
      cnt_r <= 2'h0;
      core_done <= 1'h0;
    end else if (cnt_r == {slow_r, 1'h0}) begin
      core_done <= 1'h1;
      cnt_r <= 2'h0;
      slow_r <= ~slow_r;
    end else begin
      core_done <= 1'h0;
      cnt_r <= cnt_r + 2'h1;
    end
    if (!aresetn) slow_r <= 1'h0;
  end
endmodule : core_stub

/* tb/tb_top.sv */
/*
  Self-checking bench for halt_ctl over AXI4-Lite with a core stand-in.
  Assumes the hand-over timing of halt_ctl and a 250 MHz clock.
*/
`timescale 1ns/1ps
module tb_top
  import halt_ctl_pkg::*;
;
  logic aclk, aresetn, hreset_req, halt_req, core_done, core_sync_exc, core_async_pend;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, ram_instruction_reg, seed, rd, v;
  logic [1:0] s_axi_bresp, s_axi_rresp, core_prog_rst_field, rsp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, core_mchk_enable;
  logic core_trap, core_wdog_second, core_mchk, core_unmask_enable, core_unmaskable_int;
  logic core_dbg_event, core_prog_halt, error_out, halted_flag, core_run, core_soft_rst;
  logic ram_valid, ram_mode, step_mode, async_int_allow, addr_match_enable, fetch_addr_update;
  logic msr_sync_skip, timer_direct_write, trap_halt_enable;
  logic [5:0] evp;
  int miscompares, samples_checked;
  int soft_pulses = 0, ram_pulses = 0;
  int hc_q[$] = '{4, 4, 5, 3, 3, 2, 6, 1};
  int er_q[$] = '{0, 0, 1, 1, 1, 1, 0, 0};
  assign {core_wdog_second, core_unmaskable_int, core_mchk, core_prog_halt, core_dbg_event,
    core_trap} = evp;
  halt_ctl i_dut (.*);
  core_stub i_core (.aclk, .aresetn, .halted_flag, .core_done);
  // Strobes are one cycle long, so count them as they pass
  always @(posedge aclk) begin
    if (core_soft_rst === 1'h1) soft_pulses++;
    if (ram_valid === 1'h1) ram_pulses++;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic ha, hw, hb;
    int n;
    n = 0;
    hb = 1'h0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!hb && n < 40) begin
      @(negedge aclk);
      ha = s_axi_awvalid && s_axi_awready;
      hw = s_axi_wvalid && s_axi_wready;
      hb = s_axi_bvalid;
      rsp = s_axi_bresp;
      @(posedge aclk);
      if (ha) s_axi_awvalid <= 1'h0;
      if (hw) s_axi_wvalid <= 1'h0;
      n++;
    end
    s_axi_bready <= 1'h0;
    @(posedge aclk);
    if (!hb) chk(32'h0, 32'h1, "write timeout");
  endtask : wr
  task automatic rdr(input logic [3:0] a);
    logic ha, hr;
    int n;
    n = 0;
    hr = 1'h0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    while (!hr && n < 40) begin
      @(negedge aclk);
      ha = s_axi_arvalid && s_axi_arready;
      hr = s_axi_rvalid;
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge aclk);
      if (ha) s_axi_arvalid <= 1'h0;
      n++;
    end
    s_axi_rready <= 1'h0;
    @(posedge aclk);
    if (!hr) chk(32'h0, 32'h1, "read timeout");
  endtask : rdr
  task automatic wait_halt(input logic e);
    int n;
    n = 0;
    rdr(OFF_STATUS);
    while (rd[ST_HALTED] !== e && n < 30) begin
      rdr(OFF_STATUS);
      n++;
    end
    chk({31'h0, rd[ST_HALTED]}, {31'h0, e}, "halted flag");
  endtask : wait_halt
  task automatic hard_reset();
    hreset_req <= 1'h1;
    @(posedge aclk);
    hreset_req <= 1'h0;
    @(posedge aclk);
  endtask : hard_reset
  initial begin
    aclk = 1'h0;
    forever #2 aclk = ~aclk;
  end
  initial begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    conclude();
  end
  initial begin
    {aresetn, hreset_req, halt_req, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 6'h0;
    {s_axi_arvalid, s_axi_rready, core_mchk_enable, core_unmask_enable} = 4'h0;
    {core_async_pend, core_sync_exc, evp, s_axi_awaddr, s_axi_araddr} = 16'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    core_prog_rst_field = PROG_HALT_VAL;
    seed = 32'h8C722DFD;
    miscompares = 0;
    samples_checked = 0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    rdr(OFF_STATUS);
    chk(rd & 32'h5F, 32'h0, "idle status");
    $display("test idle done");
    // Each halt cause except hardware failure from a running core, cleared by hard reset between
    for (int i = 0; i < 8; i++) begin
      wr(OFF_CFG, 32'h7);
      if (i < 6) evp <= 6'(1 << i);
      if (i == 6) halt_req <= 1'h1;
      if (i == 7) wr(OFF_CMD, {29'h0, CMD_FORCE});
      @(posedge aclk);
      evp <= 6'h0;
      wait_halt(1'h1);
      chk(rd & 32'h4F, 32'(8 | hc_q[i] | (er_q[i] << 6)), "cause");
      chk({31'h0, error_out}, 32'(er_q[i]), "error out");
      halt_req <= 1'h0;
      hard_reset();
      $display("test cause %0d done", i);
    end
    v = {29'h0, async_int_allow, addr_match_enable, trap_halt_enable};
    chk(v, 32'h7, "mode lines");
    v = rnd();
    wr(OFF_RAM, v);
    chk({30'h0, rsp}, {30'h0, RESP_SLVERR}, "ram while running");
    chk(32'(ram_pulses), 32'h0, "refused ram strobe");
    wr(OFF_STATUS, rnd());
    chk({30'h0, rsp}, {30'h0, RESP_SLVERR}, "status write");
    wr(OFF_CMD, {29'h0, CMD_HALT});
    wait_halt(1'h1);
    wr(OFF_RAM, v);
    chk({30'h0, rsp}, {30'h0, RESP_OKAY}, "ram while halted");
    chk(ram_instruction_reg, v, "ram word");
    chk(32'(ram_pulses), 32'h1, "ram strobe");
    wait_halt(1'h1);
    wr(OFF_CMD, {29'h0, CMD_SOFT_RST});
    wait_halt(1'h1);
    chk({31'h0, rd[ST_PEND]}, 32'h1, "pending after soft reset");
    wr(OFF_CMD, {29'h0, CMD_HARD_RST});
    wait_halt(1'h1);
    chk({31'h0, rd[ST_PEND]}, 32'h1, "pending after commanded reset");
    chk(32'(soft_pulses), 32'h2, "reset pulses");
    wr(OFF_CMD, {29'h0, CMD_STEP});
    wait_halt(1'h1);
    core_async_pend <= 1'h1;
    wr(OFF_CMD, {29'h0, CMD_STEP});
    wait_halt(1'h1);
    core_async_pend <= 1'h0;
    wr(OFF_CMD, {29'h0, CMD_RESTART});
    wait_halt(1'h0);
    $display("test step ram done");
    wr(OFF_CMD, {29'h0, CMD_HALT});
    wait_halt(1'h1);
    chk(rd & 32'h7, {29'h0, HC_FORCE}, "halt command cause");
    wr(OFF_CMD, {29'h0, CMD_CLEAR});
    rdr(OFF_STATUS);
    chk(rd & 32'h6F, 32'h8, "cleared status");
    hard_reset();
    rdr(OFF_STATUS);
    chk({31'h0, rd[ST_PEND]}, 32'h0, "pending after hard reset");
    chk({31'h0, rd[ST_HALTED]}, 32'h0, "running after hard reset");
    $display("test hard reset done");
    conclude();
  end
endmodule : tb_top
